// ===== design/fpu_pkg.sv
/*
 * Shared constants, encodings and carrier structs of the single-precision
 * convert / fused multiply-add / divide / extension load unit.
 * Assumes IEEE 754 binary32 and binary16 encodings and a 2-bit rounding mode
 * taken from the floating-point status/control register outside this unit.
 */
package fpu_pkg;
	localparam int WORD_W     = 32;
	localparam int HALF_W     = 16;
	localparam int SGL_FRAC_W = 23;
	localparam int SGL_EXP_W  = 8;
	localparam int SGL_BIAS   = 127;
	localparam int HLF_FRAC_W = 10;
	localparam int HLF_EXP_W  = 5;
	localparam int HLF_BIAS   = 15;
	localparam int MANT_W     = 24;
	localparam int PROD_W     = 48;
	localparam int WIN_W      = 80;
	localparam int WIN_TOP    = 78;
	localparam int INF_SCALE  = 512;
	localparam int DIV_SH     = 50;
	localparam int DIV_STEPS  = 74;
	localparam int CNT_W      = 7;
	localparam int INT_SAT_SH = 40;
	localparam int ADDR_STEP  = 4;
	localparam int IMM_W      = 10;
	localparam int REG_IDX_W  = 6;
	localparam int FBITS_W    = 6;
	localparam int SCALE_W    = 12;

	localparam logic [WORD_W-1:0] DEFAULT_NAN     = 32'h7FC0_0000;
	localparam logic [WORD_W-1:0] HLF_DEFAULT_NAN = 32'h0000_7E00;

	localparam logic [1:0] RM_NEAREST   = 2'h0;
	localparam logic [1:0] RM_PLUS_INF  = 2'h1;
	localparam logic [1:0] RM_MINUS_INF = 2'h2;
	localparam logic [1:0] RM_ZERO      = 2'h3;

	typedef enum logic [3:0] {
		CONVERT_OP_INT,
		CONVERT_CONFIGURED_ROUNDING_OP,
		CONVERT_OP_FIXED,
		CONVERT_HALF_BOTTOM_OP,
		CONVERT_HALF_TOP_OP,
		DIVIDE_OP,
		FUSED_MUL_ACC_OP,
		FUSED_MUL_SUB_OP,
		FUSED_NEG_MUL_ACC_OP,
		FUSED_NEG_MUL_SUB_OP,
		LOAD_SINGLE_OP,
		LOAD_MULTIPLE_OP
	} op_e;

	typedef enum logic [1:0] {
		SIGNED_WORD_TYPE,
		UNSIGNED_WORD_TYPE,
		SIGNED_HALF_TYPE,
		UNSIGNED_HALF_TYPE
	} num_type_e;

	typedef enum logic {
		INCREMENT_AFTER_MODE,
		DECREMENT_BEFORE_MODE
	} ldm_mode_e;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_DIVIDE,
		ST_LOAD
	} state_e;

	typedef struct packed {
		op_e                   op;
		logic                  from_float;
		num_type_e             ntype;
		logic [FBITS_W-1:0]    fbits;
		logic [WORD_W-1:0]     opa;
		logic [WORD_W-1:0]     opb;
		logic [WORD_W-1:0]     opd;
		logic [REG_IDX_W-1:0]  dest;
		logic [WORD_W-1:0]     base;
		logic [IMM_W-1:0]      imm;
		logic                  imm_sub;
		ldm_mode_e             mode;
		logic                  dword;
		logic [REG_IDX_W-1:0]  reg_count;
		logic                  writeback;
	} fp_req_s;

	typedef struct packed {
		logic                  valid;
		logic [REG_IDX_W-1:0]  dest;
		logic [WORD_W-1:0]     data;
	} res_s;

	typedef struct packed {
		logic                  req;
		logic [WORD_W-1:0]     addr;
	} mem_s;

	typedef struct packed {
		logic                  valid;
		logic [WORD_W-1:0]     data;
	} wb_s;

	typedef struct packed {
		logic                  s;
		logic signed [SCALE_W-1:0] e;
		logic [MANT_W-1:0]     m;
		logic                  inf;
		logic                  nan;
	} unp_s;

	typedef struct packed {
		state_e                state;
		res_s                  res;
		res_s                  ldw;
		mem_s                  mem;
		wb_s                   wb;
		logic [DIV_STEPS-1:0]  dnum;
		logic [MANT_W:0]       drem;
		logic [MANT_W-1:0]     dden;
		logic signed [SCALE_W-1:0] dscale;
		logic                  dsign;
		logic [1:0]            drm;
		logic [CNT_W-1:0]      cnt;
		logic [REG_IDX_W-1:0]  ld_left;
		logic [REG_IDX_W-1:0]  ld_idx;
		logic                  wb_pend;
		logic [WORD_W-1:0]     wb_val;
	} st_s;
endpackage

// ===== design/fp_convert_fma_load_unit.sv
/*
 * Single-precision execution block: float/integer, float/fixed and
 * half/single conversions, iterative divide, fused multiply-add variants
 * and extension-register loads (single and multiple) from memory.
 * Assumes the issue stage holds req_i stable while req_valid_i is high and
 * that memory answers one read at a time with mem_ack_i while mem_o.req.
 */
// How it works
// - float to int truncates, select variant uses status rounding
// - integer side is a signed or unsigned word
// - int to float uses status rounding
// - four fixed types, one register in and out
// - fixed source reads only its low bits
// - signed fixed result sign-extends
// - unsigned fixed result zero-extends
// - to fixed truncates, from fixed rounds to nearest
// - bottom op uses bits 15:0, top op bits 31:16
// - half result keeps the other half
// - divide first operand by second
// - multiply-add adds exact product, rounds once
// - multiply-subtract negates first operand
// - negate-add adds negated destination to negated product
// - negate-subtract adds negated destination to product
// - multiple load walks up from base or ends below it
// - single load address is base +/- word offset
`timescale 1ns/1ps
`default_nettype none
module fp_convert_fma_load_unit (
	input  wire logic                          mclk_i,
	input  wire logic                          rst_n_i,
	input  wire logic [1:0]                    fp_status_control_reg_rmode_i,
	input  wire logic                          req_valid_i,
	input  wire fpu_pkg::fp_req_s              req_i,
	output logic                               req_ready_o,
	output var fpu_pkg::res_s                  res_o,
	output var fpu_pkg::res_s                  ldw_o,
	output var fpu_pkg::mem_s                  mem_o,
	input  wire logic                          mem_ack_i,
	input  wire logic [fpu_pkg::WORD_W-1:0]    mem_rdata_i,
	output var fpu_pkg::wb_s                   base_wb_o
);
	localparam int W  = fpu_pkg::WORD_W;
	localparam int WW = fpu_pkg::WIN_W;

	fpu_pkg::st_s                    cur, nxt;
	fpu_pkg::unp_s                   ua, ub;
	logic [1:0]                      rm;
	logic                            sgn, w16, top;
	logic [fpu_pkg::REG_IDX_W-1:0]   ld_words;
	logic [W-1:0]                    ld_span, imm_off;
	logic [fpu_pkg::MANT_W:0]        trial;
	logic                            ge;

	function automatic logic round_inc(input logic [1:0] mode, input logic s,
			input logic r, input logic st, input logic lsb);
		logic inc;
		case (mode)
			fpu_pkg::RM_NEAREST:   inc = r & (st | lsb);
			fpu_pkg::RM_PLUS_INF:  inc = ~s & (r | st);
			fpu_pkg::RM_MINUS_INF: inc = s & (r | st);
			default:               inc = 1'b0;
		endcase
		return inc;
	endfunction

	// split into sign, lsb scale and significand
	function automatic fpu_pkg::unp_s unpack(input logic [W-1:0] x,
			input logic half);
		fpu_pkg::unp_s u;
		int ew, fw, bias, ex;
		logic [W-1:0] f;
		ew = half ? fpu_pkg::HLF_EXP_W : fpu_pkg::SGL_EXP_W;
		fw = half ? fpu_pkg::HLF_FRAC_W : fpu_pkg::SGL_FRAC_W;
		bias = half ? fpu_pkg::HLF_BIAS : fpu_pkg::SGL_BIAS;
		ex = int'((x >> fw) & ((32'h1 << ew) - 32'h1));
		f = x & ((32'h1 << fw) - 32'h1);
		u.s = x[fw+ew];
		u.inf = (ex == (1 << ew) - 1) && (f == '0);
		u.nan = (ex == (1 << ew) - 1) && (f != '0);
		if (ex == 0) begin
			u.m = f[fpu_pkg::MANT_W-1:0];
			u.e = fpu_pkg::SCALE_W'(1 - bias - fw);
		end else begin
			u.m = f[fpu_pkg::MANT_W-1:0] | (24'h1 << fw);
			u.e = fpu_pkg::SCALE_W'(ex - bias - fw);
		end
		return u;
	endfunction

	// pack m * 2**e with one rounding
	function automatic logic [W-1:0] pack(input logic s, input int e,
			input logic [WW-1:0] m, input logic [1:0] mode, input logic half);
		int fw, bias, emax, sp, p, l, ex;
		logic [WW-1:0] q;
		logic r, st, big;
		logic [W-1:0] o;
		fw = half ? fpu_pkg::HLF_FRAC_W : fpu_pkg::SGL_FRAC_W;
		bias = half ? fpu_pkg::HLF_BIAS : fpu_pkg::SGL_BIAS;
		emax = half ? (1 << fpu_pkg::HLF_EXP_W) - 1 : (1 << fpu_pkg::SGL_EXP_W) - 1;
		sp = half ? fpu_pkg::HALF_W - 1 : W - 1;
		p = -1;
		for (int i = 0; i < WW; i++) begin
			if (m[i])
				p = i;
		end
		l = p - fw;
		if (l < 1 - bias - fw - e)
			l = 1 - bias - fw - e;
		r = 1'b0;
		st = 1'b0;
		if (l <= 0) begin
			q = m << (-l);
		end else if (l > WW) begin
			q = '0;
			st = |m;
		end else begin
			q = m >> l;
			r = m[l-1];
			st = |(m & ((WW'(1) << (l - 1)) - WW'(1)));
		end
		q = q + WW'(round_inc(mode, s, r, st, q[0]));
		if (q[fw+1]) begin
			q = q >> 1;
			l = l + 1;
		end
		ex = q[fw] ? l + e + fw + bias : 0;
		big = (mode == fpu_pkg::RM_NEAREST) || (mode == fpu_pkg::RM_PLUS_INF && !s)
			|| (mode == fpu_pkg::RM_MINUS_INF && s);
		if (p < 0)
			o = 32'(s) << sp;
		else if (ex >= emax)
			o = (32'(s) << sp) | (big ? 32'(emax) << fw : (32'(emax) << fw) - 32'h1);
		else
			o = (32'(s) << sp) | (32'(ex) << fw) | (q[W-1:0] & ((32'h1 << fw) - 32'h1));
		return o;
	endfunction

	// an infinity is packed as a certain overflow
	function automatic logic [W-1:0] inf_of(input logic s, input logic half);
		return pack(s, fpu_pkg::INF_SCALE, WW'(1), fpu_pkg::RM_NEAREST, half);
	endfunction

	function automatic logic [W-1:0] to_fixed(input logic [W-1:0] x,
			input logic [1:0] mode, input logic sg, input logic h16, input int fb);
		fpu_pkg::unp_s u;
		int sc, sh, n;
		logic [63:0] m, mag, lim_p, lim_n;
		logic r, st, ovf;
		logic [W-1:0] o;
		u = unpack(x, 1'b0);
		m = 64'(u.m);
		n = h16 ? fpu_pkg::HALF_W : W;
		lim_p = sg ? (64'h1 << (n - 1)) - 64'h1 : (64'h1 << n) - 64'h1;
		lim_n = sg ? (64'h1 << (n - 1)) : 64'h0;
		sc = int'(u.e) + fb;
		r = 1'b0;
		st = 1'b0;
		ovf = u.inf;
		mag = '0;
		if (sc >= 0) begin
			if (sc > fpu_pkg::INT_SAT_SH)
				ovf = 1'b1;
			else
				mag = m << sc;
		end else begin
			sh = -sc;
			if (sh > fpu_pkg::MANT_W) begin
				st = |m;
			end else begin
				mag = m >> sh;
				r = m[sh-1];
				st = |(m & ((64'h1 << (sh - 1)) - 64'h1));
			end
		end
		mag = mag + 64'(round_inc(mode, u.s, r, st, mag[0]));
		if (u.nan)
			o = '0;
		else if (u.s)
			o = (ovf || mag > lim_n) ? 32'(-lim_n) : 32'(-mag);
		else
			o = (ovf || mag > lim_p) ? 32'(lim_p) : 32'(mag);
		if (h16 && sg)
			o = {{fpu_pkg::HALF_W{o[fpu_pkg::HALF_W-1]}}, o[fpu_pkg::HALF_W-1:0]};
		else if (h16)
			o = {{fpu_pkg::HALF_W{1'b0}}, o[fpu_pkg::HALF_W-1:0]};
		return o;
	endfunction

	function automatic logic [W-1:0] from_fixed(input logic [W-1:0] x,
			input logic [1:0] mode, input logic sg, input logic h16, input int fb);
		logic [W-1:0] v;
		logic neg;
		v = x;
		if (h16)
			v = {{fpu_pkg::HALF_W{sg & x[fpu_pkg::HALF_W-1]}}, x[fpu_pkg::HALF_W-1:0]};
		neg = sg & v[W-1];
		return pack(neg, -fb, WW'(neg ? -v : v), mode, 1'b0);
	endfunction

	function automatic logic [W-1:0] cvt_float(input logic [W-1:0] x,
			input logic src_half, input logic [1:0] mode);
		fpu_pkg::unp_s u;
		logic [W-1:0] o;
		u = unpack(x, src_half);
		if (u.nan)
			o = src_half ? fpu_pkg::DEFAULT_NAN : fpu_pkg::HLF_DEFAULT_NAN;
		else if (u.inf)
			o = inf_of(u.s, !src_half);
		else
			o = pack(u.s, int'(u.e), WW'(u.m), mode, !src_half);
		return o;
	endfunction

	function automatic logic [WW-1:0] align(input logic [WW-1:0] m, input int sh);
		logic [WW-1:0] o;
		if (sh >= 0)
			o = m << sh;
		else if (-sh >= WW)
			o = WW'(|m);
		else
			o = (m >> (-sh)) | WW'(|(m & ((WW'(1) << (-sh)) - WW'(1))));
		return o;
	endfunction

	// exact (+/-a)*b plus +/-d, one rounding
	function automatic logic [W-1:0] fma(input logic [W-1:0] a, input logic [W-1:0] b,
			input logic [W-1:0] d, input logic negp, input logic negd,
			input logic [1:0] mode);
		fpu_pkg::unp_s xa, xb, xd;
		logic sp, sd, sr;
		int ep, t, bs;
		logic [WW-1:0] mp, md, sum;
		logic [W-1:0] o;
		xa = unpack(a, 1'b0);
		xb = unpack(b, 1'b0);
		xd = unpack(d, 1'b0);
		sp = xa.s ^ xb.s ^ negp;
		sd = xd.s ^ negd;
		ep = int'(xa.e) + int'(xb.e);
		t = ep + fpu_pkg::PROD_W;
		if (int'(xd.e) + fpu_pkg::MANT_W > t)
			t = int'(xd.e) + fpu_pkg::MANT_W;
		bs = t - fpu_pkg::WIN_TOP;
		mp = align(WW'(fpu_pkg::PROD_W'(xa.m) * fpu_pkg::PROD_W'(xb.m)), ep - bs);
		md = align(WW'(xd.m), int'(xd.e) - bs);
		if (sp == sd) begin
			sum = mp + md;
			sr = sp;
		end else if (mp >= md) begin
			sum = mp - md;
			sr = sp;
		end else begin
			sum = md - mp;
			sr = sd;
		end
		if (sum == '0)
			sr = (sp == sd) ? sp : (mode == fpu_pkg::RM_MINUS_INF);
		if (xa.nan || xb.nan || xd.nan || (xa.inf && xb.m == '0)
				|| (xb.inf && xa.m == '0) || ((xa.inf || xb.inf) && xd.inf && sp != sd))
			o = fpu_pkg::DEFAULT_NAN;
		else if (xa.inf || xb.inf)
			o = inf_of(sp, 1'b0);
		else if (xd.inf)
			o = inf_of(sd, 1'b0);
		else
			o = pack(sr, bs, sum, mode, 1'b0);
		return o;
	endfunction

	assign rm = fp_status_control_reg_rmode_i;
	assign ua = unpack(req_i.opa, 1'b0);
	assign ub = unpack(req_i.opb, 1'b0);
	assign sgn = (req_i.ntype == fpu_pkg::SIGNED_WORD_TYPE)
		|| (req_i.ntype == fpu_pkg::SIGNED_HALF_TYPE);
	assign w16 = (req_i.ntype == fpu_pkg::SIGNED_HALF_TYPE)
		|| (req_i.ntype == fpu_pkg::UNSIGNED_HALF_TYPE);
	assign top = (req_i.op == fpu_pkg::CONVERT_HALF_TOP_OP);
	assign ld_words = req_i.dword ? req_i.reg_count << 1 : req_i.reg_count;
	assign ld_span = W'(ld_words) * W'(fpu_pkg::ADDR_STEP);
	assign imm_off = W'(req_i.imm) & ~W'(fpu_pkg::ADDR_STEP - 1);
	assign trial = {cur.drem[fpu_pkg::MANT_W-1:0], cur.dnum[fpu_pkg::DIV_STEPS-1]};
	assign ge = trial >= {1'b0, cur.dden};

	always_comb begin
		nxt = cur;
		nxt.res.valid = 1'b0;
		nxt.ldw.valid = 1'b0;
		nxt.wb.valid = 1'b0;
		case (cur.state)
			fpu_pkg::ST_IDLE: begin
				if (req_valid_i) begin
					nxt.res.dest = req_i.dest;
					nxt.res.valid = 1'b1;
					case (req_i.op)
						fpu_pkg::CONVERT_OP_INT,
						fpu_pkg::CONVERT_CONFIGURED_ROUNDING_OP: begin
							if (req_i.from_float)
								nxt.res.data = to_fixed(req_i.opa,
									(req_i.op == fpu_pkg::CONVERT_OP_INT) ? fpu_pkg::RM_ZERO : rm,
									sgn, 1'b0, 0);
							else
								nxt.res.data = from_fixed(req_i.opa, rm, sgn, 1'b0, 0);
						end
						fpu_pkg::CONVERT_OP_FIXED: begin
							if (req_i.from_float)
								nxt.res.data = to_fixed(req_i.opd, fpu_pkg::RM_ZERO, sgn, w16,
									int'(req_i.fbits));
							else
								nxt.res.data = from_fixed(req_i.opd, fpu_pkg::RM_NEAREST, sgn, w16,
									int'(req_i.fbits));
						end
						fpu_pkg::CONVERT_HALF_BOTTOM_OP,
						fpu_pkg::CONVERT_HALF_TOP_OP: begin
							if (req_i.from_float && top)
								nxt.res.data = {cvt_float(req_i.opa, 1'b0, rm)[fpu_pkg::HALF_W-1:0],
									req_i.opd[fpu_pkg::HALF_W-1:0]};
							else if (req_i.from_float)
								nxt.res.data = {req_i.opd[W-1:fpu_pkg::HALF_W],
									cvt_float(req_i.opa, 1'b0, rm)[fpu_pkg::HALF_W-1:0]};
							else
								nxt.res.data = cvt_float(W'(top ? req_i.opa[W-1:fpu_pkg::HALF_W]
									: req_i.opa[fpu_pkg::HALF_W-1:0]), 1'b1, rm);
						end
						fpu_pkg::DIVIDE_OP: begin
							if (ua.nan || ub.nan || (ua.inf && ub.inf) || (ua.m == '0 && ub.m == '0))
								nxt.res.data = fpu_pkg::DEFAULT_NAN;
							else if (ua.inf || ub.m == '0)
								nxt.res.data = inf_of(ua.s ^ ub.s, 1'b0);
							else if (ua.m == '0 || ub.inf)
								nxt.res.data = pack(ua.s ^ ub.s, 0, '0, rm, 1'b0);
							else begin
								// finite nonzero quotient: one bit per cycle
								nxt.res.valid = 1'b0;
								nxt.state = fpu_pkg::ST_DIVIDE;
								nxt.dnum = fpu_pkg::DIV_STEPS'(ua.m) << fpu_pkg::DIV_SH;
								nxt.drem = '0;
								nxt.dden = ub.m;
								nxt.dscale = fpu_pkg::SCALE_W'(int'(ua.e) - int'(ub.e)
									- fpu_pkg::DIV_SH - 1);
								nxt.dsign = ua.s ^ ub.s;
								nxt.drm = rm;
								nxt.cnt = fpu_pkg::CNT_W'(fpu_pkg::DIV_STEPS);
							end
						end
						fpu_pkg::FUSED_MUL_ACC_OP:
							nxt.res.data = fma(req_i.opa, req_i.opb, req_i.opd, 1'b0, 1'b0, rm);
						fpu_pkg::FUSED_MUL_SUB_OP:
							nxt.res.data = fma(req_i.opa, req_i.opb, req_i.opd, 1'b1, 1'b0, rm);
						fpu_pkg::FUSED_NEG_MUL_ACC_OP:
							nxt.res.data = fma(req_i.opa, req_i.opb, req_i.opd, 1'b1, 1'b1, rm);
						fpu_pkg::FUSED_NEG_MUL_SUB_OP:
							nxt.res.data = fma(req_i.opa, req_i.opb, req_i.opd, 1'b0, 1'b1, rm);
						fpu_pkg::LOAD_SINGLE_OP: begin
							nxt.res.valid = 1'b0;
							nxt.state = fpu_pkg::ST_LOAD;
							nxt.mem.req = 1'b1;
							nxt.mem.addr = req_i.imm_sub ? req_i.base - imm_off
								: req_i.base + imm_off;
							nxt.ld_left = req_i.dword ? fpu_pkg::REG_IDX_W'(2) : fpu_pkg::REG_IDX_W'(1);
							nxt.ld_idx = req_i.dest;
							nxt.wb_pend = 1'b0;
						end
						fpu_pkg::LOAD_MULTIPLE_OP: begin
							nxt.res.valid = 1'b0;
							if (ld_words != '0) begin
								nxt.state = fpu_pkg::ST_LOAD;
								nxt.mem.req = 1'b1;
								nxt.ld_left = ld_words;
								nxt.ld_idx = req_i.dest;
								nxt.wb_pend = req_i.writeback;
								if (req_i.mode == fpu_pkg::DECREMENT_BEFORE_MODE) begin
									nxt.mem.addr = req_i.base - ld_span;
									nxt.wb_val = req_i.base - ld_span;
								end else begin
									nxt.mem.addr = req_i.base;
									nxt.wb_val = req_i.base + ld_span;
								end
							end
						end
						default:
							nxt.res.valid = 1'b0;
					endcase
				end
			end
			fpu_pkg::ST_DIVIDE: begin
				nxt.drem = ge ? trial - {1'b0, cur.dden} : trial;
				nxt.dnum = {cur.dnum[fpu_pkg::DIV_STEPS-2:0], ge};
				nxt.cnt = cur.cnt - 1'b1;
				if (cur.cnt == fpu_pkg::CNT_W'(1)) begin
					nxt.state = fpu_pkg::ST_IDLE;
					nxt.res.valid = 1'b1;
					nxt.res.data = pack(cur.dsign, int'(cur.dscale),
						WW'({nxt.dnum, |nxt.drem}), cur.drm, 1'b0);
				end
			end
			fpu_pkg::ST_LOAD: begin
				if (mem_ack_i) begin
					nxt.ldw.valid = 1'b1;
					nxt.ldw.dest = cur.ld_idx;
					nxt.ldw.data = mem_rdata_i;
					nxt.ld_idx = cur.ld_idx + 1'b1;
					nxt.ld_left = cur.ld_left - 1'b1;
					nxt.mem.addr = cur.mem.addr + W'(fpu_pkg::ADDR_STEP);
					if (cur.ld_left == fpu_pkg::REG_IDX_W'(1)) begin
						nxt.mem.req = 1'b0;
						nxt.state = fpu_pkg::ST_IDLE;
						nxt.wb.valid = cur.wb_pend;
						nxt.wb.data = cur.wb_val;
					end
				end
			end
			default:
				nxt.state = fpu_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i)
			cur <= '0;
		else
			cur <= nxt;
	end

	assign req_ready_o = (cur.state == fpu_pkg::ST_IDLE);
	assign res_o = cur.res;
	assign ldw_o = cur.ldw;
	assign mem_o = cur.mem;
	assign base_wb_o = cur.wb;
endmodule
`default_nettype wire

// ===== verification/fpu_unit_monitor.sv
/*
 * Port checker of the fp unit: result latency, half-register keeping,
 * fixed extension and load addressing.
 * Assumes it is bound to the top module of the unit.
 */
`timescale 1ns/1ps
`default_nettype none
module fpu_unit_monitor (
	input wire logic             mclk_i,
	input wire logic             rst_n_i,
	input wire logic             req_valid_i,
	input wire fpu_pkg::fp_req_s req_i,
	input wire logic             req_ready_o,
	input wire fpu_pkg::res_s    res_o,
	input wire fpu_pkg::res_s    ldw_o,
	input wire fpu_pkg::mem_s    mem_o,
	input wire logic             mem_ack_i,
	input wire logic [31:0]      mem_rdata_i
);
	logic        take;
	logic [31:0] ofs, ldr_a, ldm_a;
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	assign take = req_valid_i && req_ready_o;
	assign ofs = {22'h0, req_i.imm[9:2], 2'h0};
	assign ldr_a = req_i.imm_sub ? req_i.base - ofs : req_i.base + ofs;
	assign ldm_a = req_i.mode == fpu_pkg::DECREMENT_BEFORE_MODE ?
		req_i.base - ({24'h0, req_i.reg_count, 2'h0} << req_i.dword) :
		req_i.base;
	property p_conv;
		take && req_i.op inside {[fpu_pkg::CONVERT_OP_INT :
			fpu_pkg::CONVERT_HALF_TOP_OP]} |=> res_o.valid;
	endproperty
	a_conv: assert property (p_conv) else $error("late convert");
	property p_fma;
		take && req_i.op inside {[fpu_pkg::FUSED_MUL_ACC_OP :
			fpu_pkg::FUSED_NEG_MUL_SUB_OP]} |=> res_o.valid;
	endproperty
	a_fma: assert property (p_fma) else $error("late fused");
	property p_div;
		take && req_i.op == fpu_pkg::DIVIDE_OP &&
			req_i.opa[30:23] inside {[8'h01:8'hFE]} &&
			req_i.opb[30:23] inside {[8'h01:8'hFE]}
			|=> !req_ready_o [*8] ##[60:70] res_o.valid;
	endproperty
	a_div: assert property (p_div) else $error("divide timing");
	property p_htop;
		take && req_i.op == fpu_pkg::CONVERT_HALF_TOP_OP && req_i.from_float
			|=> res_o.data[15:0] == $past(req_i.opd[15:0]);
	endproperty
	a_htop: assert property (p_htop) else $error("low half lost");
	property p_hbot;
		take && req_i.op == fpu_pkg::CONVERT_HALF_BOTTOM_OP && req_i.from_float
			|=> res_o.data[31:16] == $past(req_i.opd[31:16]);
	endproperty
	a_hbot: assert property (p_hbot) else $error("top half lost");
	property p_sext;
		take && req_i.op == fpu_pkg::CONVERT_OP_FIXED && req_i.from_float &&
			req_i.ntype == fpu_pkg::SIGNED_HALF_TYPE
			|=> res_o.data[31:16] == {16{res_o.data[15]}};
	endproperty
	a_sext: assert property (p_sext) else $error("no sign ext");
	property p_zext;
		take && req_i.op == fpu_pkg::CONVERT_OP_FIXED && req_i.from_float &&
			req_i.ntype == fpu_pkg::UNSIGNED_HALF_TYPE
			|=> res_o.data[31:16] == 16'h0000;
	endproperty
	a_zext: assert property (p_zext) else $error("no zero ext");
	property p_ldr;
		take && req_i.op == fpu_pkg::LOAD_SINGLE_OP
			|=> mem_o.req && mem_o.addr == $past(ldr_a);
	endproperty
	a_ldr: assert property (p_ldr) else $error("single addr");
	property p_ldm;
		take && req_i.op == fpu_pkg::LOAD_MULTIPLE_OP && req_i.reg_count != 6'h0
			|=> mem_o.req && mem_o.addr == $past(ldm_a);
	endproperty
	a_ldm: assert property (p_ldm) else $error("multiple addr");
	property p_step;
		mem_o.req && mem_ack_i
			|=> !mem_o.req || mem_o.addr == $past(mem_o.addr) + 32'h4;
	endproperty
	a_step: assert property (p_step) else $error("addr step");
	property p_ldw;
		mem_o.req && mem_ack_i
			|=> ldw_o.valid && ldw_o.data == $past(mem_rdata_i);
	endproperty
	a_ldw: assert property (p_ldw) else $error("load word");
endmodule
`default_nettype wire

// ===== verification/fpu_mem_model.sv
/*
 * Memory read partner: acks a held request after wait_i idle cycles.
 * Assumes the unit holds mem_i.req and addr until the ack edge.
 */
`timescale 1ns/1ps
`default_nettype none
module fpu_mem_model (
	input  wire logic          clk_i,
	input  wire logic          rst_n_i,
	input  wire fpu_pkg::mem_s mem_i,
	input  wire logic [3:0]    wait_i,
	output logic               ack_o,
	output logic [31:0]        rdata_o
);
	logic [3:0]  cnt_ff;
	logic [31:0] last_ff;
	assign ack_o = mem_i.req && (cnt_ff == wait_i);
	// data outside the ack cycle is inverted so stale reads show up
	assign rdata_o = ack_o ? {mem_i.addr[15:0], ~mem_i.addr[15:0]} : ~last_ff;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cnt_ff  <= 4'h0;
			last_ff <= 32'h0;
		end else begin
			cnt_ff  <= (ack_o || !mem_i.req) ? 4'h0 : cnt_ff + 4'h1;
			last_ff <= rdata_o;
		end
	end
endmodule
`default_nettype wire

// ===== verification/fp_convert_fma_load_unit_tb.sv
/*
 * Self-checking bench of the fp convert / fused / divide / load unit.
 * Assumes fpu_mem_model answers the unit's memory port.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin \
	bad_count++; $display("MISMATCH %s exp %h got %h", nm, e, g); end end
module fp_convert_fma_load_unit_tb;
	logic             clk, rst_n, vld, rdy, ack;
	logic [1:0]       rm;
	logic [3:0]       mwait;
	logic [31:0]      rdata;
	fpu_pkg::fp_req_s req;
	fpu_pkg::res_s    res, ldw;
	fpu_pkg::mem_s    mem;
	fpu_pkg::wb_s     wb;
	int               bad_count, checks;

	fp_convert_fma_load_unit dut (.mclk_i(clk), .rst_n_i(rst_n),
		.fp_status_control_reg_rmode_i(rm), .req_valid_i(vld), .req_i(req),
		.req_ready_o(rdy), .res_o(res), .ldw_o(ldw), .mem_o(mem),
		.mem_ack_i(ack), .mem_rdata_i(rdata), .base_wb_o(wb));
	fpu_mem_model mem_model (.clk_i(clk), .rst_n_i(rst_n), .mem_i(mem),
		.wait_i(mwait), .ack_o(ack), .rdata_o(rdata));

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic issue(input fpu_pkg::fp_req_s r);
		@(posedge clk);
		vld <= 1'b1;
		req <= r;
		@(posedge clk);
		vld <= 1'b0;
	endtask

	task automatic rnd(input logic [1:0] m);
		@(posedge clk);
		rm <= m;
	endtask

	task automatic run(input fpu_pkg::op_e op, input logic ff,
			input fpu_pkg::num_type_e nt, input logic [5:0] fb,
			input logic [31:0] a, b, d, e);
		fpu_pkg::fp_req_s r;
		int               n;
		r = '0;
		r.op = op;
		r.from_float = ff;
		r.ntype = nt;
		r.fbits = fb;
		r.opa = a;
		r.opb = b;
		r.opd = d;
		r.dest = 6'h05;
		issue(r);
		n = 0;
		#1;
		while (res.valid !== 1'b1 && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		`CHK("res_o.data", e, res.data)
		`CHK("res_o.dest", 6'h05, res.dest)
	endtask

	task automatic ld(input fpu_pkg::op_e op, input logic [31:0] base,
			input logic [9:0] imm, input logic sub, db, dw, wbk,
			input logic [5:0] cnt, input logic [31:0] a0, wbv, input int nw);
		fpu_pkg::fp_req_s r;
		logic [31:0]      a;
		int               n;
		r = '0;
		r.op = op;
		r.base = base;
		r.imm = imm;
		r.imm_sub = sub;
		r.mode = fpu_pkg::ldm_mode_e'(db);
		r.dword = dw;
		r.writeback = wbk;
		r.reg_count = cnt;
		r.dest = 6'h02;
		issue(r);
		for (int k = 0; k < nw; k++) begin
			a = a0 + 32'(4 * k);
			n = 0;
			do begin
				@(posedge clk);
				#1;
				n++;
			end while (ldw.valid !== 1'b1 && n < 50);
			`CHK("ldw_o.dest", r.dest + 6'(k), ldw.dest)
			`CHK("ldw_o.data", {a[15:0], ~a[15:0]}, ldw.data)
		end
		`CHK("base_wb_o.valid", wbk, wb.valid)
		if (wbk)
			`CHK("base_wb_o.data", wbv, wb.data)
	endtask

	task automatic t_int;
		rnd(fpu_pkg::RM_NEAREST);
		run(fpu_pkg::CONVERT_OP_INT, 1'b1, fpu_pkg::SIGNED_WORD_TYPE, 6'h00,
			32'h4030_0000, 32'h0, 32'h0, 32'h0000_0002);
		run(fpu_pkg::CONVERT_CONFIGURED_ROUNDING_OP, 1'b1,
			fpu_pkg::SIGNED_WORD_TYPE, 6'h00, 32'h4030_0000, 32'h0, 32'h0,
			32'h0000_0003);
		run(fpu_pkg::CONVERT_OP_INT, 1'b1, fpu_pkg::UNSIGNED_WORD_TYPE, 6'h00,
			32'hC030_0000, 32'h0, 32'h0, 32'h0);
		rnd(fpu_pkg::RM_PLUS_INF);
		run(fpu_pkg::CONVERT_OP_INT, 1'b0, fpu_pkg::SIGNED_WORD_TYPE, 6'h00,
			32'h0100_0001, 32'h0, 32'h0, 32'h4B80_0001);
	endtask

	task automatic t_fix;
		run(fpu_pkg::CONVERT_OP_FIXED, 1'b1, fpu_pkg::SIGNED_HALF_TYPE, 6'h04,
			32'h0, 32'h0, 32'hBFC0_0000, 32'hFFFF_FFE8);
		run(fpu_pkg::CONVERT_OP_FIXED, 1'b1, fpu_pkg::UNSIGNED_HALF_TYPE, 6'h01,
			32'h0, 32'h0, 32'h3FC8_0000, 32'h0000_0003);
		run(fpu_pkg::CONVERT_OP_FIXED, 1'b1, fpu_pkg::SIGNED_WORD_TYPE, 6'h20,
			32'h0, 32'h0, 32'hBF00_0000, 32'h8000_0000);
		rnd(fpu_pkg::RM_ZERO);
		run(fpu_pkg::CONVERT_OP_FIXED, 1'b0, fpu_pkg::SIGNED_HALF_TYPE, 6'h04,
			32'h0, 32'h0, 32'hABCD_0018, 32'h3FC0_0000);
		run(fpu_pkg::CONVERT_OP_FIXED, 1'b0, fpu_pkg::UNSIGNED_WORD_TYPE, 6'h01,
			32'h0, 32'h0, 32'h0100_0003, 32'h4B00_0002);
	endtask

	task automatic t_half_div_fma;
		rnd(fpu_pkg::RM_NEAREST);
		run(fpu_pkg::CONVERT_HALF_TOP_OP, 1'b1, fpu_pkg::SIGNED_WORD_TYPE, 6'h00,
			32'h3F80_0000, 32'h0, 32'h1234_5678, 32'h3C00_5678);
		run(fpu_pkg::CONVERT_HALF_BOTTOM_OP, 1'b1, fpu_pkg::SIGNED_WORD_TYPE,
			6'h00, 32'h3F80_0000, 32'h0, 32'h1234_5678, 32'h1234_3C00);
		run(fpu_pkg::CONVERT_HALF_TOP_OP, 1'b0, fpu_pkg::SIGNED_WORD_TYPE, 6'h00,
			32'hC000_3C00, 32'h0, 32'h0, 32'hC000_0000);
		run(fpu_pkg::DIVIDE_OP, 1'b0, fpu_pkg::SIGNED_WORD_TYPE, 6'h00,
			32'h3F80_0000, 32'h4040_0000, 32'h0, 32'h3EAA_AAAB);
		for (int k = 0; k < 4; k++)
			run(fpu_pkg::op_e'(fpu_pkg::FUSED_MUL_ACC_OP + k), 1'b0,
				fpu_pkg::SIGNED_WORD_TYPE, 6'h00, 32'h3F80_0800, 32'h3F80_0800,
				{~k[0], 31'h3F80_1000},
				{k[0] ^ k[1], 31'h3380_0000});
	endtask

	task automatic t_ld;
		mwait = 4'h0;
		ld(fpu_pkg::LOAD_SINGLE_OP, 32'h2000_0100, 10'h3FC, 1'b1, 1'b0, 1'b1,
			1'b0, 6'h00, 32'h1FFF_FD04, 32'h0, 2);
		mwait = 4'h2;
		ld(fpu_pkg::LOAD_SINGLE_OP, 32'h2000_0100, 10'h3FC, 1'b0, 1'b0, 1'b0,
			1'b0, 6'h00, 32'h2000_04FC, 32'h0, 1);
		mwait = 4'h1;
		ld(fpu_pkg::LOAD_MULTIPLE_OP, 32'h0000_0100, 10'h0, 1'b0, 1'b0, 1'b0,
			1'b1, 6'h02, 32'h0000_0100, 32'h0000_0108, 2);
		mwait = 4'h0;
		ld(fpu_pkg::LOAD_MULTIPLE_OP, 32'h0000_1000, 10'h0, 1'b0, 1'b1, 1'b1,
			1'b1, 6'h10, 32'h0000_0F80, 32'h0000_0F80, 32);
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	initial begin
		#(25 * 5000);
		bad_count++;
		tally_and_finish();
	end

	initial begin
		rst_n = 1'b0;
		vld = 1'b0;
		req = '0;
		rm = fpu_pkg::RM_NEAREST;
		mwait = 4'h0;
		bad_count = 0;
		checks = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		t_int();
		t_fix();
		t_half_div_fma();
		t_ld();
		tally_and_finish();
	end
endmodule
bind fp_convert_fma_load_unit fpu_unit_monitor mon (.mclk_i(mclk_i),
	.rst_n_i(rst_n_i), .req_valid_i(req_valid_i), .req_i(req_i),
	.req_ready_o(req_ready_o), .res_o(res_o), .ldw_o(ldw_o),
	.mem_o(mem_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i));
`default_nettype wire
